/* File: hw/trig_seq_pkg.sv */
// Package with constants and types for the trigger and reading sequencer.
package trig_seq_pkg;

  // Clock rate and time base.
  localparam int unsigned CLK_HZ = 100_000_000;
  localparam int unsigned US_PER_S = 1_000_000;
  localparam int unsigned TICK_US = 1;
  localparam int unsigned TICK_CYCLES = CLK_HZ / US_PER_S * TICK_US;

  // Burst length limits and default.
  localparam logic [15:0] SAMPLE_COUNT_MIN = 16'h0001;
  localparam logic [15:0] SAMPLE_COUNT_MAX = 16'hC350;
  localparam logic [15:0] SAMPLE_COUNT_DEFAULT = 16'h0001;

  // Delay limits in seconds and in microsecond ticks.
  localparam int unsigned DELAY_MAX_S = 3600;
  localparam logic [31:0] DELAY_MAX_TICKS = 32'(DELAY_MAX_S) * 32'(US_PER_S / TICK_US);
  localparam logic [31:0] ZERO_DELAY_TICKS = 32'h0000_0000;

  // Hold filter needs this many consecutive out-of-band readings.
  localparam logic [1:0] HOLD_OUT_COUNT = 2'h3;

  // Band divisors: 0.01%, 0.1%, 1% and 10% of the held reading.
  localparam logic [15:0] BAND_DIV_0P01 = 16'h2710;
  localparam logic [15:0] BAND_DIV_0P1 = 16'h03E8;
  localparam logic [15:0] BAND_DIV_1 = 16'h0064;
  localparam logic [15:0] BAND_DIV_10 = 16'h000A;

  // Flash half period of the run/hold indicator, in ticks.
  localparam logic [31:0] FLASH_HALF_TICKS = 32'h0007_A120;

  // Width of the active-low completion pulse, in clock cycles.
  localparam logic [7:0] PULSE_CYCLES = 8'h0A;

  typedef enum logic [1:0] {SRC_AUTO, SRC_SINGLE, SRC_EXTERNAL, SRC_LEVEL} trig_src_e;
  typedef enum logic [1:0] {DLY_AUTO, DLY_ZERO, DLY_MANUAL} delay_mode_e;
  typedef enum logic [1:0] {BAND_0P01, BAND_0P1, BAND_1, BAND_10} band_e;
  typedef enum logic [1:0] {FN_DC_VOLTAGE, FN_DC_CURRENT, FN_RESISTANCE, FN_OTHER} meas_fn_e;

  localparam band_e BAND_DEFAULT = BAND_0P1;
  localparam trig_src_e SRC_DEFAULT = SRC_AUTO;

  // Configuration bundle.
  typedef struct packed {
    trig_src_e src;
    logic slope_falling;
    delay_mode_e delay_mode;
    logic [31:0] manual_delay_ticks;
    logic [15:0] sample_count;
    logic hold_enable;
    band_e band;
    logic completion_pulse_enable;
    meas_fn_e func;
    logic signed [23:0] trig_level;
  } trig_cfg_s;

  // One reading delivered by the converter.
  typedef struct packed {
    logic valid;
    logic signed [23:0] value;
  } reading_s;

endpackage

/* File: hw/tick_counter.sv */
// Down counter loaded with a tick count that reports when it has run out.
`timescale 1ns/1ps
module tick_counter (
  input wire logic i_clk,
  input wire logic i_arst_n,
  input wire logic i_tick,
  input wire logic i_load,
  input wire logic [31:0] i_count,
  output logic o_done
);

  logic [31:0] count_r;

  // Load restarts the count; each tick brings it one closer to zero.
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      count_r <= 32'h0000_0000;
    end else if (i_load) begin
      count_r <= i_count;
    end else if (i_tick && count_r != 32'h0000_0000) begin
      count_r <= count_r - 32'h0000_0001;
    end
  end

  assign o_done = (count_r == 32'h0000_0000) && !i_load;

endmodule // tick_counter

/* File: hw/trigger_reading_sequencer.sv */
// Trigger source selection, burst sequencing, reading hold and completion pulse.
`timescale 1ns/1ps
//
// Function
// - Four trigger sources: automatic, single command, external edge, level crossing.
// - Each trigger takes sample_count readings, 1 to 50000, default 1.
// - After configuration reset the automatic source is selected.
// - Automatic source restarts readings back to back without waiting.
// - Single source starts one burst per command assertion.
// - External source starts a burst on the chosen edge of the input.
// - Level source fires on crossing the level; only DC volts, current, resistance.
// - Slope picks rising or falling for external and level sources.
// - The delay is inserted before every reading of the burst.
// - Automatic delay comes from function, range, integration time and filter.
// - Zero delay mode waits nothing before each reading.
// - Manual delay is a user value from 0 s to 3600 s.
// - Hold replaces the held reading after three consecutive out-of-band readings.
// - Hold band is 0.01, 0.1, 1 or 10 percent, default 0.1.
// - The run/hold indicator flashes while hold is enabled.
// - When enabled, each measurement starts or stretches an active-low completion pulse.
module trigger_reading_sequencer
  import trig_seq_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_arst_n,
  input wire logic i_cfg_reset,
  input wire trig_cfg_s i_cfg,
  input wire logic i_cfg_write,
  input wire logic [31:0] i_auto_delay_ticks,
  input wire logic i_single_cmd,
  input wire logic i_external_trigger_input,
  input wire reading_s i_reading,
  output logic o_reading_start,
  output logic o_busy,
  output trig_src_e o_src,
  output logic [15:0] o_sample_count,
  output logic signed [23:0] o_display_value,
  output logic o_display_valid,
  output logic o_run_hold_led,
  output logic o_meas_complete_output_n
);

  typedef enum {ST_IDLE, ST_DELAY, ST_MEASURE} seq_state_e;

  ////////////////////////////////////////////////////////////////////////////
  // Configuration

  trig_cfg_s cfg_r;
  logic [15:0] count_clamped;
  logic [31:0] manual_clamped;
  logic level_allowed;

  // Out-of-range settings are clamped into the legal span.
  always_comb begin
    count_clamped = i_cfg.sample_count;
    if (count_clamped < SAMPLE_COUNT_MIN) begin
      count_clamped = SAMPLE_COUNT_MIN;
    end else if (count_clamped > SAMPLE_COUNT_MAX) begin
      count_clamped = SAMPLE_COUNT_MAX;
    end
    manual_clamped = (i_cfg.manual_delay_ticks > DELAY_MAX_TICKS) ? DELAY_MAX_TICKS
                     : i_cfg.manual_delay_ticks;
  end

  assign level_allowed = (i_cfg.func == FN_DC_VOLTAGE) || (i_cfg.func == FN_DC_CURRENT)
                         || (i_cfg.func == FN_RESISTANCE);

  // The configuration register; a level source on other functions falls back to auto.
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      cfg_r <= '0;
      cfg_r.src <= SRC_DEFAULT;
      cfg_r.sample_count <= SAMPLE_COUNT_DEFAULT;
      cfg_r.band <= BAND_DEFAULT;
      cfg_r.func <= FN_DC_VOLTAGE;
    end else if (i_cfg_reset) begin
      cfg_r <= '0;
      cfg_r.src <= SRC_DEFAULT;
      cfg_r.sample_count <= SAMPLE_COUNT_DEFAULT;
      cfg_r.band <= BAND_DEFAULT;
      cfg_r.func <= FN_DC_VOLTAGE;
    end else if (i_cfg_write) begin
      cfg_r <= i_cfg;
      cfg_r.sample_count <= count_clamped;
      cfg_r.manual_delay_ticks <= manual_clamped;
      if (i_cfg.src == SRC_LEVEL && !level_allowed) begin
        cfg_r.src <= SRC_AUTO;
      end
    end
  end

  assign o_src = cfg_r.src;
  assign o_sample_count = cfg_r.sample_count;

  ////////////////////////////////////////////////////////////////////////////
  // Time base

  logic [6:0] tick_div_r;
  logic tick;

  // One-cycle microsecond tick enable.
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      tick_div_r <= 7'h00;
    end else if (tick_div_r == 7'(TICK_CYCLES - 1)) begin
      tick_div_r <= 7'h00;
    end else begin
      tick_div_r <= tick_div_r + 7'h01;
    end
  end

  assign tick = (tick_div_r == 7'(TICK_CYCLES - 1));

  ////////////////////////////////////////////////////////////////////////////
  // Trigger event detection

  logic ext_meta_r;
  logic ext_sync_r;
  logic ext_prev_r;
  logic ext_edge;
  logic single_prev_r;
  logic single_rise;
  logic signed [23:0] prev_value_r;
  logic prev_value_ok_r;
  logic level_cross;
  logic trig_event;

  // Two-stage synchroniser on the external pin, then edge memory.
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      ext_meta_r <= 1'b0;
      ext_sync_r <= 1'b0;
      ext_prev_r <= 1'b0;
    end else begin
      ext_meta_r <= i_external_trigger_input;
      ext_sync_r <= ext_meta_r;
      ext_prev_r <= ext_sync_r;
    end
  end

  // Edge selected by the slope setting.
  assign ext_edge = cfg_r.slope_falling ? (ext_prev_r && !ext_sync_r)
                    : (!ext_prev_r && ext_sync_r);

  // Single command acts on its rising edge only.
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      single_prev_r <= 1'b0;
    end else begin
      single_prev_r <= i_single_cmd;
    end
  end

  assign single_rise = i_single_cmd && !single_prev_r;

  // Last reading remembered for level crossing detection.
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      prev_value_r <= 24'sh000000;
      prev_value_ok_r <= 1'b0;
    end else if (i_cfg_write || i_cfg_reset) begin
      prev_value_ok_r <= 1'b0;
    end else if (i_reading.valid) begin
      prev_value_r <= i_reading.value;
      prev_value_ok_r <= 1'b1;
    end
  end

  // Crossing in the chosen direction between two successive readings.
  always_comb begin
    level_cross = 1'b0;
    if (i_reading.valid && prev_value_ok_r) begin
      if (cfg_r.slope_falling) begin
        level_cross = (prev_value_r >= cfg_r.trig_level) && (i_reading.value < cfg_r.trig_level);
      end else begin
        level_cross = (prev_value_r <= cfg_r.trig_level) && (i_reading.value > cfg_r.trig_level);
      end
    end
  end

  // Source mux; automatic fires whenever the sequencer is idle.
  always_comb begin
    case (cfg_r.src)
      SRC_AUTO: trig_event = 1'b1;
      SRC_SINGLE: trig_event = single_rise;
      SRC_EXTERNAL: trig_event = ext_edge;
      SRC_LEVEL: trig_event = level_cross;
      default: trig_event = 1'b0;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Burst sequencer

  seq_state_e state_r;
  logic [15:0] remaining_r;
  logic [31:0] delay_ticks;
  logic delay_load;
  logic delay_done;

  // Delay for the present mode.
  always_comb begin
    case (cfg_r.delay_mode)
      DLY_AUTO: delay_ticks = i_auto_delay_ticks;
      DLY_ZERO: delay_ticks = ZERO_DELAY_TICKS;
      DLY_MANUAL: delay_ticks = cfg_r.manual_delay_ticks;
      default: delay_ticks = ZERO_DELAY_TICKS;
    endcase
  end

  assign delay_load = (state_r == ST_IDLE && trig_event)
                      || (state_r == ST_MEASURE && i_reading.valid && remaining_r != 16'h0001);

  tick_counter u_delay (
    .i_clk(i_clk),
    .i_arst_n(i_arst_n),
    .i_tick(tick),
    .i_load(delay_load),
    .i_count(delay_ticks),
    .o_done(delay_done)
  );

  // Idle takes triggers; events seen while busy are dropped.
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      state_r <= ST_IDLE;
      remaining_r <= 16'h0000;
    end else if (i_cfg_reset || i_cfg_write) begin
      state_r <= ST_IDLE;
      remaining_r <= 16'h0000;
    end else begin
      case (state_r)
        ST_IDLE: begin
          if (trig_event) begin
            state_r <= ST_DELAY;
            remaining_r <= cfg_r.sample_count;
          end
        end
        ST_DELAY: begin
          if (delay_done) begin
            state_r <= ST_MEASURE;
          end
        end
        ST_MEASURE: begin
          if (i_reading.valid) begin
            remaining_r <= remaining_r - 16'h0001;
            state_r <= (remaining_r == 16'h0001) ? ST_IDLE : ST_DELAY;
          end
        end
        default: state_r <= ST_IDLE;
      endcase
    end
  end

  // Start pulse to the converter when the delay ends.
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_reading_start <= 1'b0;
    end else begin
      o_reading_start <= (state_r == ST_DELAY) && delay_done && !i_cfg_reset && !i_cfg_write;
    end
  end

  assign o_busy = (state_r != ST_IDLE);

  ////////////////////////////////////////////////////////////////////////////
  // Completion pulse

  logic [7:0] pulse_cnt_r;
  logic measure_done;

  assign measure_done = (state_r == ST_MEASURE) && i_reading.valid;

  // Each completed reading starts an active-low pulse if enabled.
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      pulse_cnt_r <= 8'h00;
      o_meas_complete_output_n <= 1'b1;
    end else if (measure_done && cfg_r.completion_pulse_enable) begin
      pulse_cnt_r <= PULSE_CYCLES;
      o_meas_complete_output_n <= 1'b0;
    end else if (pulse_cnt_r > 8'h01) begin
      pulse_cnt_r <= pulse_cnt_r - 8'h01;
    end else begin
      pulse_cnt_r <= 8'h00;
      o_meas_complete_output_n <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Reading hold

  logic signed [23:0] held_r;
  logic [1:0] out_cnt_r;
  logic [23:0] held_mag;
  logic [23:0] band;
  logic [23:0] diff_mag;
  logic signed [24:0] diff;
  logic out_of_band;

  // Band width as a fraction of the held reading.
  always_comb begin
    held_mag = held_r[23] ? 24'(-held_r) : 24'(held_r);
    case (cfg_r.band)
      BAND_0P01: band = 24'(held_mag / BAND_DIV_0P01);
      BAND_0P1: band = 24'(held_mag / BAND_DIV_0P1);
      BAND_1: band = 24'(held_mag / BAND_DIV_1);
      BAND_10: band = 24'(held_mag / BAND_DIV_10);
      default: band = 24'(held_mag / BAND_DIV_0P1);
    endcase
    diff = 25'(i_reading.value) - 25'(held_r);
    diff_mag = diff[24] ? 24'(-diff) : 24'(diff);
    out_of_band = diff_mag > band;
  end

  // Held value changes after three consecutive out-of-band readings.
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      held_r <= 24'sh000000;
      out_cnt_r <= 2'h0;
      o_display_valid <= 1'b0;
    end else if (i_reading.valid) begin
      o_display_valid <= 1'b1;
      if (!cfg_r.hold_enable || !o_display_valid) begin
        held_r <= i_reading.value;
        out_cnt_r <= 2'h0;
      end else if (!out_of_band) begin
        out_cnt_r <= 2'h0;
      end else if (out_cnt_r == HOLD_OUT_COUNT - 2'h1) begin
        held_r <= i_reading.value;
        out_cnt_r <= 2'h0;
      end else begin
        out_cnt_r <= out_cnt_r + 2'h1;
      end
    end
  end

  assign o_display_value = held_r;

  ////////////////////////////////////////////////////////////////////////////
  // Run/hold indicator

  logic [31:0] flash_cnt_r;
  logic flash_r;

  // Blinks while hold is on, steady lit otherwise.
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      flash_cnt_r <= 32'h0000_0000;
      flash_r <= 1'b1;
    end else if (!cfg_r.hold_enable) begin
      flash_cnt_r <= 32'h0000_0000;
      flash_r <= 1'b1;
    end else if (tick) begin
      if (flash_cnt_r >= FLASH_HALF_TICKS - 32'h0000_0001) begin
        flash_cnt_r <= 32'h0000_0000;
        flash_r <= !flash_r;
      end else begin
        flash_cnt_r <= flash_cnt_r + 32'h0000_0001;
      end
    end
  end

  assign o_run_hold_led = flash_r;

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  a_pulse_needs_enable: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    $fell(o_meas_complete_output_n) |-> $past(cfg_r.completion_pulse_enable))
    else $error("Completion pulse without enable.");

  // A retrigger only stretches the pulse, so at least ten low samples, the fall sample included, must be seen.
  a_pulse_width: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    $fell(o_meas_complete_output_n) |-> !o_meas_complete_output_n [*8] ##1 !o_meas_complete_output_n
    ##1 !o_meas_complete_output_n)
    else $error("Completion pulse too short.");

  a_busy_no_restart: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    (state_r == ST_DELAY) && !delay_done && !i_cfg_write && !i_cfg_reset |=> state_r != ST_IDLE)
    else $error("Burst dropped during delay.");

  a_burst_load_count: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    (state_r == ST_IDLE) && trig_event && !i_cfg_write && !i_cfg_reset |=> remaining_r == cfg_r.sample_count)
    else $error("Burst length not loaded.");

  a_cfg_reset_auto: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    i_cfg_reset |=> o_src == SRC_AUTO)
    else $error("Source not automatic after configuration reset.");

  a_auto_immediate: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    (state_r == ST_IDLE) && cfg_r.src == SRC_AUTO && !i_cfg_write && !i_cfg_reset |=> state_r == ST_DELAY)
    else $error("Automatic source waited.");

  // A configuration write in the cycle after the trigger aborts the burst, so it is left out.
  a_zero_delay_start: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    ((state_r == ST_IDLE) && trig_event && cfg_r.delay_mode == DLY_ZERO && !i_cfg_write && !i_cfg_reset)
    ##1 (!i_cfg_write && !i_cfg_reset) |=> o_reading_start)
    else $error("Zero delay did not start reading at once.");

  a_count_range: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    cfg_r.sample_count >= SAMPLE_COUNT_MIN && cfg_r.sample_count <= SAMPLE_COUNT_MAX)
    else $error("Sample count out of range.");

  a_hold_steady: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    cfg_r.hold_enable && o_display_valid && i_reading.valid && !out_of_band |=> $stable(held_r))
    else $error("Held reading changed inside band.");

  a_led_steady_off: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    !cfg_r.hold_enable |=> o_run_hold_led)
    else $error("Indicator flashing without hold.");

endmodule // trigger_reading_sequencer

/* File: bench/far_side.sv */
// Far side model: external trigger source, converter and completion pulse receiver.
`timescale 1ns/1ps
module far_side
  import trig_seq_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_arst_n,
  input wire logic i_reading_start,
  input wire logic i_complete_n,
  output logic o_ext_trig,
  output reading_s o_reading
);
  logic [2:0] lat_r;
  logic feed_req = 1'b0;
  logic signed [23:0] next_value = 24'sh000000;
  int start_count;
  int pulse_count;
  int low_len;
  int last_low;

  initial o_ext_trig = 1'b0;

  ////////////////////////////////////////////////////////////
  // Conversion answers four clocks after a start; the value lines toggle when nothing is valid.
  always @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      lat_r <= 3'h0;
      o_reading <= '0;
      start_count <= 0;
      pulse_count <= 0;
      low_len <= 0;
      last_low <= 0;
    end else begin
      lat_r <= {lat_r[1:0], i_reading_start};
      o_reading.valid <= lat_r[2] | feed_req;
      o_reading.value <= (lat_r[2] | feed_req) ? next_value : ~o_reading.value;
      if (i_reading_start) start_count <= start_count + 1;
      if (!i_complete_n && low_len == 0) pulse_count <= pulse_count + 1;
      if (!i_complete_n) begin
        low_len <= low_len + 1;
      end else if (low_len != 0) begin
        last_low <= low_len;
        low_len <= 0;
      end
    end
  end

  ////////////////////////////////////////////////////////////
  // Trigger pin level; callers hold each level for many clocks.
  task automatic ext_set(input logic v);
    @(posedge i_clk);
    #1;
    o_ext_trig = v;
  endtask

  // A reading that arrives without a start request.
  task automatic feed_reading(input logic signed [23:0] v);
    next_value = v;
    feed_req = 1'b1;
    @(posedge i_clk);
    #1;
    feed_req = 1'b0;
  endtask
endmodule // far_side

/* File: bench/test_trigger_reading_sequencer.sv */
// Self-checking bench for the trigger and reading sequencer.
`timescale 1ns/1ps
module test_trigger_reading_sequencer
  import trig_seq_pkg::*;
;
  logic i_clk, i_arst_n, i_cfg_reset, i_cfg_write, i_single_cmd, ext_trig;
  logic start, busy, disp_valid, led, done_n;
  logic [31:0] i_auto_delay_ticks;
  logic [15:0] scount;
  logic signed [23:0] disp, v;
  trig_cfg_s cfg;
  reading_s reading;
  trig_src_e src;
  int bad_count, num_checks, seed, cyc, last_st, gap, base, pb, k, n, h, d;

  trigger_reading_sequencer trigger_reading_sequencer_i (
    .i_clk(i_clk),
    .i_arst_n(i_arst_n),
    .i_cfg_reset(i_cfg_reset),
    .i_cfg(cfg),
    .i_cfg_write(i_cfg_write),
    .i_auto_delay_ticks(i_auto_delay_ticks),
    .i_single_cmd(i_single_cmd),
    .i_external_trigger_input(ext_trig),
    .i_reading(reading),
    .o_reading_start(start),
    .o_busy(busy),
    .o_src(src),
    .o_sample_count(scount),
    .o_display_value(disp),
    .o_display_valid(disp_valid),
    .o_run_hold_led(led),
    .o_meas_complete_output_n(done_n)
  );

  far_side far_side_i (
    .i_clk(i_clk),
    .i_arst_n(i_arst_n),
    .i_reading_start(start),
    .i_complete_n(done_n),
    .o_ext_trig(ext_trig),
    .o_reading(reading)
  );

  ////////////////////////////////////////////////////////////
  // Free running clock.
  initial begin
    i_clk = 1'b0;
    forever #5 i_clk = ~i_clk;
  end

  // Clocks between successive conversion starts.
  always @(posedge i_clk) begin
    cyc <= cyc + 1;
    if (start === 1'b1) begin
      gap <= cyc - last_st;
      last_st <= cyc;
    end
  end

  ////////////////////////////////////////////////////////////
  // Advance c edges, then settle inputs one nanosecond later.
  task automatic step(input int c);
    repeat (c) @(posedge i_clk);
    #1;
  endtask

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("[ERR] %s expected %0h seen %0h", what, exp, seen);
    end
  endtask

  task automatic complete_run();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic wr();
    i_cfg_write = 1'b1;
    step(1);
    i_cfg_write = 1'b0;
    step(1);
  endtask

  task automatic fire();
    i_single_cmd = 1'b1;
    step(1);
    i_single_cmd = 1'b0;
    step(2);
  endtask

  task automatic wait_idle();
    int t;
    t = 0;
    while (busy !== 1'b0 && t < 5000) begin
      step(1);
      t++;
    end
    if (t >= 5000) begin
      chk("idle wait", 32'h1, 32'h0);
      complete_run();
    end
  endtask

  task automatic feed(input int val);
    far_side_i.feed_reading(24'(val));
    step(3);
  endtask

  // Allowed gap between two starts of a burst for a delay of dt ticks.
  function automatic logic gap_ok(input int g, input int dt);
    int lo;
    lo = (dt == 0) ? 2 : dt * int'(TICK_CYCLES) - 95;
    return g >= lo && g <= dt * int'(TICK_CYCLES) + 112;
  endfunction

  function automatic int band_div(input int b);
    return (b == 0) ? 10000 : (b == 1) ? 1000 : (b == 2) ? 100 : 10;
  endfunction

  // Bounds the whole run.
  initial begin
    #900000;
    chk("run time", 32'h1, 32'h0);
    complete_run();
  end

  ////////////////////////////////////////////////////////////
  // Main sequence.
  initial begin
    seed = 57;
    i_arst_n = 1'b0;
    i_cfg_reset = 1'b0;
    i_cfg_write = 1'b0;
    i_single_cmd = 1'b0;
    i_auto_delay_ticks = 32'h0000_0000;
    cfg = '0;
    step(3);
    i_arst_n = 1'b1;
    chk("reset src", 32'(src), 32'(SRC_AUTO));
    chk("reset count", 32'(scount), 32'h1);
    chk("reset led", 32'(led), 32'h1);
    base = far_side_i.start_count;
    step(100);
    chk("auto starts", 32'(far_side_i.start_count - base > 7), 32'h1);
    $display("auto test done");
    cfg.src = SRC_SINGLE;
    cfg.delay_mode = DLY_ZERO;
    wr();
    chk("count low clamp", 32'(scount), 32'h1);
    cfg.sample_count = 16'hEA60;
    wr();
    chk("count high clamp", 32'(scount), 32'hC350);
    cfg.delay_mode = DLY_MANUAL;
    cfg.manual_delay_ticks = 32'h3;
    for (k = 0; k < 5; k++) begin
      n = (k < 2) ? 1 + 3 * k : 1 + ($random(seed) & 3);
      far_side_i.next_value = 24'($random(seed));
      cfg.sample_count = 16'(n);
      cfg.completion_pulse_enable = (k % 2 == 0);
      wr();
      base = far_side_i.start_count;
      pb = far_side_i.pulse_count;
      fire();
      step(20);
      fire();
      wait_idle();
      step(15);
      chk("burst starts", far_side_i.start_count - base, n);
      chk("pulses", far_side_i.pulse_count - pb, (k % 2 == 0) ? n : 0);
      if (k % 2 == 0) chk("pulse width", far_side_i.last_low, 32'(PULSE_CYCLES));
    end
    $display("single test done");
    cfg.delay_mode = DLY_ZERO;
    cfg.src = SRC_EXTERNAL;
    cfg.sample_count = 16'h1;
    for (k = 0; k < 2; k++) begin
      cfg.slope_falling = k[0];
      wr();
      base = far_side_i.start_count;
      far_side_i.ext_set(1'b1);
      step(15);
      chk("ext after rise", far_side_i.start_count - base, 1 - k);
      far_side_i.ext_set(1'b0);
      step(15);
      chk("ext after fall", far_side_i.start_count - base, 1);
    end
    $display("external test done");
    cfg.src = SRC_SINGLE;
    cfg.sample_count = 16'h2;
    i_auto_delay_ticks = 32'h3;
    for (k = 0; k < 4; k++) begin
      cfg.delay_mode = (k == 0) ? DLY_ZERO : (k == 3) ? DLY_AUTO : DLY_MANUAL;
      cfg.manual_delay_ticks = (k == 2) ? 32'h2 : 32'h0;
      d = (k == 2) ? 2 : (k == 3) ? 3 : 0;
      wr();
      fire();
      wait_idle();
      chk("delay gap", 32'(gap_ok(gap, d)), 32'h1);
    end
    $display("delay test done");
    cfg.src = SRC_LEVEL;
    cfg.sample_count = 16'h1;
    cfg.delay_mode = DLY_ZERO;
    for (k = 0; k < 2; k++) begin
      cfg.slope_falling = k[0];
      wr();
      base = far_side_i.start_count;
      v = k[0] ? 24'sd100 : -24'sd100;
      feed(v);
      feed(-v);
      step(12);
      feed(v);
      step(12);
      chk("level starts", far_side_i.start_count - base, 1);
    end
    for (k = 0; k < 4; k++) begin
      cfg.src = SRC_LEVEL;
      cfg.func = meas_fn_e'(k);
      wr();
      chk("level function", 32'(src), 32'((k == 3) ? SRC_AUTO : SRC_LEVEL));
    end
    $display("level test done");
    cfg.src = SRC_SINGLE;
    cfg.func = FN_DC_VOLTAGE;
    h = 1000000;
    for (k = 0; k < 4; k++) begin
      d = band_div(k);
      cfg.hold_enable = 1'b0;
      wr();
      feed(h);
      chk("follow", 32'(disp), 32'(h));
      chk("display valid", 32'(disp_valid), 32'h1);
      chk("led steady", 32'(led), 32'h1);
      cfg.hold_enable = 1'b1;
      cfg.band = band_e'(k);
      wr();
      feed(h + 2 * h / d);
      feed(h + 2 * h / d);
      feed(h + h / (2 * d));
      feed(h + 2 * h / d);
      feed(h + 2 * h / d);
      chk("held", 32'(disp), 32'(h));
      feed(h + 2 * h / d);
      chk("replaced", 32'(disp), 32'(h + 2 * h / d));
    end
    $display("hold test done");
    i_cfg_reset = 1'b1;
    step(1);
    i_cfg_reset = 1'b0;
    step(1);
    chk("cfg reset src", 32'(src), 32'(SRC_AUTO));
    chk("cfg reset count", 32'(scount), 32'h1);
    $display("config reset test done");
    complete_run();
  end
endmodule // test_trigger_reading_sequencer
